// ---- hw/clock_synth_map.vh ----
/*
 * Register offsets, field positions, reset values and decode constants
 * for the synthesizer frequency-selection block.
 * Assumes byte-wide registers addressed by the serial-bus byte index.
 */
`ifndef CLOCK_SYNTH_MAP_VH
`define CLOCK_SYNTH_MAP_VH

// Register byte offsets
`define OFS_N_VALUE 8'h0D
`define OFS_M_VALUE 8'h0E
`define OFS_VTEST 8'h0F
`define OFS_RSVD_A 8'h10
`define OFS_RSVD_B 8'h11

// Field positions in the M-value register
`define M_EN_BIT 7
`define M_VAL_MSB 6

// Vendor test bits occupy the low bits of the vendor test byte, just below the reserved ones
`define VTEST_MSB 2

// Reset values
`define RST_N_VALUE 8'h00
`define RST_M_VALUE 7'h00
`define RST_EN 1'b0
`define RST_VTEST 3'h3
`define RST_CODE 5'h00

// Reset values of the registered outputs
`define RST_CPU_DMHZ 11'h000
`define RST_PCI_DMHZ 9'h000
`define RST_GEAR 26'h0000000

// Readback filler for bits and bytes with no storage
`define RSVD_READ 8'h00
`define VTEST_PAD 5'h00

// PLL gear constant in millionths (same for every rate code)
`define GEAR_CONST_UMHZ 26'h2DC6EE5

`endif

// ---- hw/rate_code_decode.v ----
/*
 * Rate-code lookup: 5-bit code to CPU and PCI frequency, in 0.1 MHz units.
 * Purely combinational; the instantiating module registers the results.
 */
`timescale 1ns/1ps
module rate_code_decode (
    input wire [4:0] code_i,
    output reg [10:0] cpu_dmhz_o,
    output reg [8:0] pci_dmhz_o
);

    // Frequency table, one entry per code
    always @* begin
        case (code_i)
            5'h00: begin cpu_dmhz_o = 11'd2000; pci_dmhz_o = 9'd333; end
            5'h01: begin cpu_dmhz_o = 11'd1900; pci_dmhz_o = 9'd380; end
            5'h02: begin cpu_dmhz_o = 11'd1800; pci_dmhz_o = 9'd360; end
            5'h03: begin cpu_dmhz_o = 11'd1700; pci_dmhz_o = 9'd340; end
            5'h04: begin cpu_dmhz_o = 11'd1660; pci_dmhz_o = 9'd332; end
            5'h05: begin cpu_dmhz_o = 11'd1600; pci_dmhz_o = 9'd320; end
            5'h06: begin cpu_dmhz_o = 11'd1500; pci_dmhz_o = 9'd375; end
            5'h07: begin cpu_dmhz_o = 11'd1450; pci_dmhz_o = 9'd363; end
            5'h08: begin cpu_dmhz_o = 11'd1400; pci_dmhz_o = 9'd350; end
            5'h09: begin cpu_dmhz_o = 11'd1360; pci_dmhz_o = 9'd340; end
            5'h0A: begin cpu_dmhz_o = 11'd1300; pci_dmhz_o = 9'd325; end
            5'h0B: begin cpu_dmhz_o = 11'd1240; pci_dmhz_o = 9'd310; end
            5'h0C: begin cpu_dmhz_o = 11'd672; pci_dmhz_o = 9'd336; end
            5'h0D: begin cpu_dmhz_o = 11'd1008; pci_dmhz_o = 9'd336; end
            5'h0E: begin cpu_dmhz_o = 11'd1180; pci_dmhz_o = 9'd393; end
            5'h0F: begin cpu_dmhz_o = 11'd1344; pci_dmhz_o = 9'd336; end
            5'h10: begin cpu_dmhz_o = 11'd670; pci_dmhz_o = 9'd335; end
            5'h11: begin cpu_dmhz_o = 11'd1005; pci_dmhz_o = 9'd335; end
            5'h12: begin cpu_dmhz_o = 11'd1150; pci_dmhz_o = 9'd383; end
            5'h13: begin cpu_dmhz_o = 11'd1340; pci_dmhz_o = 9'd335; end
            5'h14: begin cpu_dmhz_o = 11'd668; pci_dmhz_o = 9'd334; end
            5'h15: begin cpu_dmhz_o = 11'd1002; pci_dmhz_o = 9'd334; end
            5'h16: begin cpu_dmhz_o = 11'd1100; pci_dmhz_o = 9'd367; end
            5'h17: begin cpu_dmhz_o = 11'd1336; pci_dmhz_o = 9'd334; end
            5'h18: begin cpu_dmhz_o = 11'd1050; pci_dmhz_o = 9'd350; end
            5'h19: begin cpu_dmhz_o = 11'd900; pci_dmhz_o = 9'd300; end
            5'h1A: begin cpu_dmhz_o = 11'd850; pci_dmhz_o = 9'd283; end
            5'h1B: begin cpu_dmhz_o = 11'd780; pci_dmhz_o = 9'd390; end
            5'h1C: begin cpu_dmhz_o = 11'd666; pci_dmhz_o = 9'd333; end
            5'h1D: begin cpu_dmhz_o = 11'd1000; pci_dmhz_o = 9'd333; end
            5'h1E: begin cpu_dmhz_o = 11'd750; pci_dmhz_o = 9'd375; end
            5'h1F: begin cpu_dmhz_o = 11'd1333; pci_dmhz_o = 9'd333; end
            default: begin cpu_dmhz_o = 11'd2000; pci_dmhz_o = 9'd333; end
        endcase
    end

endmodule

// ---- hw/clock_synth_freq_select.v ----
/*
 * Frequency-selection control of the system clock synthesizer: N/M
 * programming registers, programmable enable, strap/software rate-code
 * selection and rate-code decode for the PLL.
 * Everything the PLL and the readback path see is registered here, so
 * a write shows on the outputs one clock after it lands in a register.
 * Assumes the software rate code and its priority bit are held in
 * registers outside this block and arrive as plain levels.
 * Assumes a serial-bus byte engine in front that presents each written
 * byte as a one-cycle strobe after the byte is received and acknowledged,
 * and strap pins that are stable at reset release.
 */
`timescale 1ns/1ps
`include "clock_synth_map.vh"

module clock_synth_freq_select (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire byte_wr_i,
    input wire [7:0] byte_addr_i,
    input wire [7:0] byte_wdata_i,
    input wire [7:0] rd_addr_i,
    input wire [4:0] strap_rate_code_i,
    input wire soft_code_priority_i,
    input wire [4:0] soft_rate_code_i,
    output reg [7:0] rd_data_o,
    output reg prog_freq_en_o,
    output reg [7:0] synth_n_value_o,
    output reg [6:0] synth_m_value_o,
    output reg load_pulse_o,
    output reg [4:0] active_rate_code_o,
    output reg [10:0] cpu_dmhz_o,
    output reg [8:0] pci_dmhz_o,
    output reg [25:0] gear_const_o
);

    // Register bytes live here as flops; the readback and PLL copies are
    // registered again below, so every port comes straight from a flop.

    // Register file held by this block
    reg [7:0] n_value_r; // Programmed N
    reg [6:0] m_value_r; // Programmed M
    reg prog_en_r; // Programmable enable
    reg [2:0] vtest_r; // Vendor test bits

    // Strap capture state
    reg [4:0] strap_code_r; // Strap code caught after reset
    reg strap_taken_r; // Strap capture done

    // Rate-code selection and lookup
    reg [4:0] sel_code; // Code picked by override
    wire [10:0] cpu_tab; // Table CPU frequency
    wire [8:0] pci_tab; // Table PCI frequency

    // Write decode; each strobe stands for one whole acknowledged byte
    wire n_wr_hit; // Write aimed at the N byte
    wire m_wr_hit; // Write aimed at the M/enable byte
    wire vtest_wr_hit; // Write aimed at the vendor test byte

    assign n_wr_hit = byte_wr_i && (byte_addr_i == `OFS_N_VALUE);
    assign m_wr_hit = byte_wr_i && (byte_addr_i == `OFS_M_VALUE);
    assign vtest_wr_hit = byte_wr_i && (byte_addr_i == `OFS_VTEST);

    // Writes to the two reserved bytes and to unmapped offsets match no
    // decode below and are dropped without a trace
    // N register: taken whole from the byte, no partial update
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            n_value_r <= `RST_N_VALUE;
        end else if (n_wr_hit) begin
            // N alone starts no load; it waits for the M write
            n_value_r <= byte_wdata_i;
        end
    end

    // M register and enable share one byte and one strobe
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            m_value_r <= `RST_M_VALUE;
            prog_en_r <= `RST_EN;
        end else if (m_wr_hit) begin
            // Enable and M land together so the PLL never sees a mix
            prog_en_r <= byte_wdata_i[`M_EN_BIT];
            m_value_r <= byte_wdata_i[`M_VAL_MSB:0];
        end
    end

    // Vendor test bits; upper bits of the byte have no storage
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vtest_r <= `RST_VTEST;
        end else if (vtest_wr_hit) begin
            // Stored as written; the host is trusted to keep 0,1,1
            vtest_r <= byte_wdata_i[`VTEST_MSB:0];
        end
    end

    // Strap code is caught once, on the first edge after reset release
    // Later pin changes are ignored until the next reset
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Nothing latched yet; code zero until the first edge
            strap_code_r <= `RST_CODE;
            strap_taken_r <= 1'b0;
        end else if (!strap_taken_r) begin
            // Single capture, then the latch freezes
            strap_code_r <= strap_rate_code_i;
            strap_taken_r <= 1'b1;
        end
    end

    // Override picks the software code, else the latched strap code
    // The same choice feeds the ratio and the code output, enable set or not
    always @* begin
        if (soft_code_priority_i) begin
            // Software code has priority
            sel_code = soft_rate_code_i;
        end else begin
            // Power-on strap code
            sel_code = strap_code_r;
        end
    end

    // Table lookup of the selected code
    // Pure lookup; the result is registered before it leaves the block
    rate_code_decode u_decode (
        .code_i(sel_code),
        .cpu_dmhz_o(cpu_tab),
        .pci_dmhz_o(pci_tab)
    );

    // N, M and enable copies handed to the PLL as they stand
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prog_freq_en_o <= `RST_EN;
            synth_n_value_o <= `RST_N_VALUE;
            synth_m_value_o <= `RST_M_VALUE;
        end else begin
            // Enable set: the PLL builds the CPU clock from N and M
            prog_freq_en_o <= prog_en_r;
            synth_n_value_o <= n_value_r;
            synth_m_value_o <= m_value_r;
        end
    end

    // Load pulse: one cycle per M byte write, even if the value repeats
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_pulse_o <= 1'b0;
        end else begin
            // N writes stay silent, so N must be in place before M
            load_pulse_o <= m_wr_hit;
        end
    end

    // Selected rate code and its table frequencies
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_rate_code_o <= `RST_CODE;
            cpu_dmhz_o <= `RST_CPU_DMHZ;
            pci_dmhz_o <= `RST_PCI_DMHZ;
        end else begin
            // Enable clear: these set the output frequencies
            // Enable set: they give the ratio between clock groups
            active_rate_code_o <= sel_code;
            cpu_dmhz_o <= cpu_tab;
            pci_dmhz_o <= pci_tab;
        end
    end

    // Gear constant; one value serves every code of either source
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gear_const_o <= `RST_GEAR;
        end else begin
            // Driven from the first edge after reset onward
            gear_const_o <= `GEAR_CONST_UMHZ;
        end
    end

    // Readback of the register bytes, one edge after the address
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= `RSVD_READ;
        end else begin
            case (rd_addr_i)
                `OFS_N_VALUE: begin
                    // N byte as stored
                    rd_data_o <= n_value_r;
                end
                `OFS_M_VALUE: begin
                    // Enable in the top bit above M
                    rd_data_o <= {prog_en_r, m_value_r};
                end
                `OFS_VTEST: begin
                    // Unused upper bits read zero
                    rd_data_o <= {`VTEST_PAD, vtest_r};
                end
                `OFS_RSVD_A: begin
                    // Reserved byte with no storage
                    rd_data_o <= `RSVD_READ;
                end
                `OFS_RSVD_B: begin
                    // Reserved byte with no storage
                    rd_data_o <= `RSVD_READ;
                end
                default: begin
                    // Offsets outside this block read zero
                    rd_data_o <= `RSVD_READ;
                end
            endcase
        end
    end

endmodule

// ---- tb/clock_synth_sva.sv ----
/* Port checker for clock_synth_freq_select.
   Assumes rst_n_i is released clear of clk_sys_i edges. */
`timescale 1ns/1ps
module clock_synth_sva (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic byte_wr_i,
    input wire logic [7:0] byte_addr_i,
    input wire logic [7:0] byte_wdata_i,
    input wire logic [4:0] strap_rate_code_i,
    input wire logic soft_code_priority_i,
    input wire logic [4:0] soft_rate_code_i,
    input wire logic prog_freq_en_o,
    input wire logic [7:0] synth_n_value_o,
    input wire logic [6:0] synth_m_value_o,
    input wire logic load_pulse_o,
    input wire logic [4:0] active_rate_code_o,
    input wire logic [25:0] gear_const_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire m_wr = byte_wr_i && byte_addr_i == 8'h0E; // Write to the M byte
    wire n_wr = byte_wr_i && byte_addr_i == 8'h0D; // Write to the N byte
    logic [4:0] strap_r; // Strap code seen at first edge after reset
    logic seen_r; // Set once that edge has passed
    // Capture the strap code the way the block latches it
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen_r <= 1'b0;
            strap_r <= 5'h00;
        end else begin
            seen_r <= 1'b1;
            if (!seen_r) strap_r <= strap_rate_code_i;
        end
    end
    load_on_m_a: assert property (m_wr |=> load_pulse_o)
        else $error("no load pulse");
    load_cause_a: assert property (load_pulse_o |-> $past(m_wr, 1))
        else $error("stray load pulse");
    m_store_a: assert property (m_wr |-> ##2 {prog_freq_en_o, synth_m_value_o} == $past(byte_wdata_i, 2))
        else $error("M byte not applied");
    n_store_a: assert property (n_wr |-> ##2 synth_n_value_o == $past(byte_wdata_i, 2))
        else $error("N byte not applied");
    reset_val_a: assert property ($rose(rst_n_i) |-> !prog_freq_en_o && synth_n_value_o == 8'h00
        && synth_m_value_o == 7'h00)
        else $error("bad reset value");
    gear_const_a: assert property ($past(rst_n_i) |-> gear_const_o == 26'h2DC6EE5)
        else $error("bad gear constant");
    soft_sel_a: assert property (soft_code_priority_i |=> active_rate_code_o == $past(soft_rate_code_i))
        else $error("soft code not used");
    strap_sel_a: assert property (seen_r && !soft_code_priority_i |=> active_rate_code_o == strap_r)
        else $error("strap code not used");
endmodule
bind clock_synth_freq_select clock_synth_sva clock_synth_sva_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .byte_wr_i(byte_wr_i), .byte_addr_i(byte_addr_i), .byte_wdata_i(byte_wdata_i),
    .strap_rate_code_i(strap_rate_code_i), .soft_code_priority_i(soft_code_priority_i),
    .soft_rate_code_i(soft_rate_code_i), .prog_freq_en_o(prog_freq_en_o), .synth_n_value_o(synth_n_value_o),
    .synth_m_value_o(synth_m_value_o), .load_pulse_o(load_pulse_o), .active_rate_code_o(active_rate_code_o),
    .gear_const_o(gear_const_o));

// ---- tb/host_model.sv ----
/* Serial-bus host model: hands over whole acknowledged bytes.
   Assumes a free-running clk_i from the bench. */
`timescale 1ns/1ps
module host_model (
    input wire logic clk_i,
    output logic byte_wr_o,
    output logic [7:0] byte_addr_o,
    output logic [7:0] byte_wdata_o
);
    initial begin
        byte_wr_o = 1'b0;
        byte_addr_o = 8'h00;
        byte_wdata_o = 8'h00;
    end
    // One strobe per byte, only after the byte is complete and acknowledged
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        byte_wr_o = 1'b1;
        byte_addr_o = a;
        byte_wdata_o = d;
        @(posedge clk_i);
        #1;
        byte_wr_o = 1'b0;
        byte_addr_o = ~a; // Released lines show the inverse
        byte_wdata_o = ~d;
    endtask
endmodule

// ---- tb/testbench.sv ----
/* Self-checking bench for clock_synth_freq_select.
   Assumes host_model and the bound checker are compiled first. */
`timescale 1ns/1ps
module testbench;
    logic clk_sys_i, rst_n_i, byte_wr_i, soft_code_priority_i, prog_freq_en_o, load_pulse_o;
    logic [7:0] byte_addr_i, byte_wdata_i, rd_addr_i, rd_data_o, synth_n_value_o;
    logic [6:0] synth_m_value_o;
    logic [4:0] strap_rate_code_i, soft_rate_code_i, active_rate_code_o;
    logic [10:0] cpu_dmhz_o;
    logic [8:0] pci_dmhz_o;
    logic [25:0] gear_const_o;
    int n_mismatch = 0, n_tests = 0, cyc = 0, n_load = 0;
    // Expected frequencies per code, 0.1 MHz units
    int cpu_t [32] = '{2000, 1900, 1800, 1700, 1660, 1600, 1500, 1450, 1400, 1360, 1300, 1240, 672, 1008, 1180,
        1344, 670, 1005, 1150, 1340, 668, 1002, 1100, 1336, 1050, 900, 850, 780, 666, 1000, 750, 1333};
    int pci_t [32] = '{333, 380, 360, 340, 332, 320, 375, 363, 350, 340, 325, 310, 336, 336, 393, 336, 335,
        335, 383, 335, 334, 334, 367, 334, 350, 300, 283, 390, 333, 333, 375, 333};
    clock_synth_freq_select clock_synth_freq_select_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .byte_wr_i(byte_wr_i), .byte_addr_i(byte_addr_i), .byte_wdata_i(byte_wdata_i), .rd_addr_i(rd_addr_i),
        .strap_rate_code_i(strap_rate_code_i), .soft_code_priority_i(soft_code_priority_i),
        .soft_rate_code_i(soft_rate_code_i), .rd_data_o(rd_data_o), .prog_freq_en_o(prog_freq_en_o),
        .synth_n_value_o(synth_n_value_o), .synth_m_value_o(synth_m_value_o), .load_pulse_o(load_pulse_o),
        .active_rate_code_o(active_rate_code_o), .cpu_dmhz_o(cpu_dmhz_o), .pci_dmhz_o(pci_dmhz_o),
        .gear_const_o(gear_const_o));
    // Load pulses counted mid-cycle, where the output is settled
    always @(negedge clk_sys_i) begin
        n_load += load_pulse_o;
    end
    host_model host_model_inst (.clk_i(clk_sys_i), .byte_wr_o(byte_wr_i), .byte_addr_o(byte_addr_i),
        .byte_wdata_o(byte_wdata_i));
    task automatic chk(input logic [25:0] got, input logic [25:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    // Register read, answer one edge later
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        #1 rd_addr_i = a;
        @(posedge clk_sys_i);
        #1 chk(rd_data_o, e, "read");
    endtask
    task automatic t_reset();
        rd(8'h0D, 8'h00);
        rd(8'h0E, 8'h00);
        rd(8'h0F, 8'h03);
        rd(8'h10, 8'h00);
        rd(8'h11, 8'h00);
        $display("test reset done");
    endtask
    // N then M back to back: exactly one load pulse; a repeated M write adds a second
    task automatic t_prog();
        int k;
        k = n_load;
        host_model_inst.write_byte(8'h0D, 8'h64);
        host_model_inst.write_byte(8'h0E, 8'h85);
        repeat (4) @(posedge clk_sys_i);
        #1 chk(n_load - k, 1, "load count");
        chk({prog_freq_en_o, synth_m_value_o, synth_n_value_o}, 16'h8564, "N M");
        rd(8'h0E, 8'h85);
        rd(8'h0D, 8'h64);
        host_model_inst.write_byte(8'h0E, 8'h85);
        repeat (2) @(posedge clk_sys_i);
        #1 chk(n_load - k, 2, "load again");
        $display("test prog done");
    endtask
    // Reset in mid-run after programming: registers return to defaults
    task automatic t_rst2();
        host_model_inst.write_byte(8'h0D, 8'h5A);
        host_model_inst.write_byte(8'h0E, 8'h9C);
        rd(8'h0E, 8'h9C);
        rst_n_i = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1 rst_n_i = 1'b1;
        rd(8'h0D, 8'h00);
        rd(8'h0E, 8'h00);
        chk({prog_freq_en_o, synth_m_value_o, synth_n_value_o}, 16'h0000, "reset N M");
        rd(8'h0F, 8'h03);
        $display("test reset again done");
    endtask
    task automatic t_rsvd();
        host_model_inst.write_byte(8'h0F, 8'hFB);
        host_model_inst.write_byte(8'h10, 8'hFF);
        host_model_inst.write_byte(8'h11, 8'hFF);
        rd(8'h0F, 8'h03);
        rd(8'h10, 8'h00);
        rd(8'h11, 8'h00);
        rd(8'h20, 8'h00);
        $display("test reserved done");
    endtask
    // Every code through the software path, enable set
    task automatic t_decode();
        soft_code_priority_i = 1'b1;
        for (int i = 0; i < 32; i++) begin
            soft_rate_code_i = i[4:0];
            repeat (2) @(posedge clk_sys_i);
            #1 chk(active_rate_code_o, i[4:0], "code");
            chk(cpu_dmhz_o, cpu_t[i][10:0], "cpu");
            chk(pci_dmhz_o, pci_t[i][8:0], "pci");
            chk(gear_const_o, 26'h2DC6EE5, "gear");
        end
        $display("test decode done");
    endtask
    // Enable clear: strap code, then software code
    task automatic t_strap();
        host_model_inst.write_byte(8'h0E, 8'h00);
        soft_code_priority_i = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1 chk({prog_freq_en_o, active_rate_code_o, cpu_dmhz_o, pci_dmhz_o}, {6'h0D, 11'd1008, 9'd336}, "strap");
        soft_code_priority_i = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1 chk({cpu_dmhz_o, pci_dmhz_o}, {11'd1333, 9'd333}, "soft");
        $display("test strap done");
    endtask
    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // Hang guard
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        {rst_n_i, soft_code_priority_i, soft_rate_code_i, rd_addr_i} = '0;
        strap_rate_code_i = 5'h0D;
        repeat (8) @(posedge clk_sys_i);
        #1 rst_n_i = 1'b1;
        t_reset();
        t_prog();
        t_rsvd();
        t_decode();
        t_strap();
        t_rst2();
        print_verdict();
    end
endmodule
